// ===== inc/sns_pkg.sv
// Purpose: Shared constants for the score note scheduler.
// Assumes: One 100 MHz system clock; note records arrive on the same clock.
// Notes:   Record fields are packed with the beat number in the top bits.
package sns_pkg;

	// Clock and tempo scaling.
	localparam int unsigned CLK_PERIOD_NS  = 10;
	localparam int unsigned NS_PER_SEC     = 1000000000;
	localparam int unsigned CLK_HZ         = NS_PER_SEC / CLK_PERIOD_NS;
	localparam int unsigned SEC_PER_MIN    = 60;
	localparam int unsigned TEMPO_SCALE    = 4;
	localparam int unsigned TICKS_PER_BEAT = 128;

	// Widths.
	localparam int unsigned TEMPO_W = 10;
	localparam int unsigned BEAT_W  = 12;
	localparam int unsigned TICK_W  = 7;
	localparam int unsigned DUR_W   = 13;
	localparam int unsigned INST_W  = 7;
	localparam int unsigned PITCH_W = 7;
	localparam int unsigned REC_W   = 46;

	// Memory depths.
	localparam int unsigned NOTE_DEPTH = 256;
	localparam int unsigned NOTE_AW    = 8;
	localparam int unsigned INST_N     = 128;

	// Record field positions, lowest bit of each field.
	localparam int unsigned REC_PITCH_LSB = 0;
	localparam int unsigned REC_INST_LSB  = REC_PITCH_LSB + PITCH_W;
	localparam int unsigned REC_DUR_LSB   = REC_INST_LSB + INST_W;
	localparam int unsigned REC_START_LSB = REC_DUR_LSB + DUR_W;
	localparam int unsigned REC_BEAT_LSB  = REC_START_LSB + TICK_W;

	// Reset and restart values.
	localparam logic [BEAT_W-1:0] BEAT_RESET = 12'h000;
	localparam logic [TICK_W-1:0] TICK_INIT  = 7'h7f;
	localparam logic [TICK_W-1:0] TICK_LAST  = 7'h7f;
	localparam logic [DUR_W-1:0]  DUR_RESET  = 13'h0000;
	localparam logic [DUR_W-1:0]  DUR_ONE    = 13'h0001;

	// Divider widths for the tick period.
	localparam int unsigned NUM_W = 36;
	localparam int unsigned DIV_W = TEMPO_W + TICK_W;
	localparam int unsigned PER_W = 28;
	localparam logic [NUM_W-1:0] TICK_NUM =
		NUM_W'(64'(CLK_HZ) * 64'(SEC_PER_MIN) * 64'(TEMPO_SCALE));

	typedef enum logic [1:0] {
		SNS_IDLE,
		SNS_SCAN,
		SNS_DECR
	} sns_state_t;

endpackage

// ===== core/sns_tick_gen.sv
// Purpose: Divides the system clock into ticks from the tempo input.
// Assumes: Tempo is four times the beats per minute; zero tempo stops ticks.
// Notes:   The period is re-divided every cycle, trading area for no tempo lag.
module sns_tick_gen #(
	parameter logic [sns_pkg::NUM_W-1:0] TICK_NUM = sns_pkg::TICK_NUM
) (
	input  wire logic                         clk,
	input  wire logic                         resetn,
	input  wire logic [sns_pkg::TEMPO_W-1:0]  tempo,
	input  wire logic                         restart,
	output logic                              tick_pulse
);

	logic [sns_pkg::DIV_W-1:0] divisor;
	logic [sns_pkg::NUM_W-1:0] quotient;
	logic [sns_pkg::PER_W-1:0] period;
	logic [sns_pkg::PER_W-1:0] cycle_count;
	logic                      period_done;

	// Ticks per minute is tempo times ticks per beat over the tempo scale.
	assign divisor     = {tempo, sns_pkg::TICK_W'(0)};
	assign quotient    = (divisor == '0) ? '0 : TICK_NUM / sns_pkg::NUM_W'(divisor);
	assign period      = sns_pkg::PER_W'(quotient);
	assign period_done = (period != '0) && (cycle_count >= period - 1'b1);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cycle_count <= '0;
			tick_pulse  <= 1'b0;
		end
		else if (restart || period_done)
		begin
			cycle_count <= '0;
			tick_pulse  <= period_done && !restart;
		end
		else
		begin
			cycle_count <= cycle_count + 1'b1;
			tick_pulse  <= 1'b0;
		end
	end

endmodule // sns_tick_gen

// ===== core/sns_scheduler.sv
// Purpose: Schedules buffered notes onto per-instrument enable and pitch outputs.
// Assumes: Beat level, tempo and fetch stream come from logic on the same clock.
// Notes:   A tick that lands during a scan or sweep is held and served once the sweep ends.

module sns_scheduler #(
	parameter int unsigned                PITCH_W  = sns_pkg::PITCH_W,
	parameter logic [sns_pkg::NUM_W-1:0]  TICK_NUM = sns_pkg::TICK_NUM
) (
	input  wire logic                                  clk,
	input  wire logic                                  resetn,
	input  wire logic                                  beat_level,
	input  wire logic [sns_pkg::TEMPO_W-1:0]           tempo,
	input  wire logic                                  fetch_busy,
	input  wire logic [sns_pkg::REC_W-1:0]             fetch_record,
	output logic      [sns_pkg::BEAT_W-1:0]            beat_number,
	output logic      [sns_pkg::TICK_W-1:0]            tick_count,
	output logic      [sns_pkg::INST_N-1:0]            inst_enable,
	output logic      [sns_pkg::INST_N*PITCH_W-1:0]    inst_pitch
);

	// Field extraction, used only for records read back from the buffer during the scan.
	function automatic logic [sns_pkg::TICK_W-1:0] rec_start(
		input logic [sns_pkg::REC_W-1:0] rec
	);
		rec_start = rec[sns_pkg::REC_START_LSB +: sns_pkg::TICK_W];
	endfunction

	function automatic logic [sns_pkg::DUR_W-1:0] rec_dur(
		input logic [sns_pkg::REC_W-1:0] rec
	);
		rec_dur = rec[sns_pkg::REC_DUR_LSB +: sns_pkg::DUR_W];
	endfunction

	function automatic logic [sns_pkg::INST_W-1:0] rec_inst(
		input logic [sns_pkg::REC_W-1:0] rec
	);
		rec_inst = rec[sns_pkg::REC_INST_LSB +: sns_pkg::INST_W];
	endfunction

	function automatic logic [PITCH_W-1:0] rec_pitch(
		input logic [sns_pkg::REC_W-1:0] rec
	);
		rec_pitch = PITCH_W'(rec[sns_pkg::REC_PITCH_LSB +: sns_pkg::PITCH_W]);
	endfunction

	// Storage.
	logic [sns_pkg::REC_W-1:0]   note_buf [sns_pkg::NOTE_DEPTH];
	logic [sns_pkg::DUR_W-1:0]   dur_mem  [sns_pkg::INST_N];

	// Beat and fill state.
	logic                        beat_prev;
	logic                        beat_pulse;
	logic [sns_pkg::NOTE_AW-1:0] wr_ptr;
	logic [sns_pkg::NOTE_AW:0]   note_count;
	logic                        buf_full;
	logic                        fill_en;

	// Tick and scan state.
	logic                        tick_pulse;
	logic                        tick_pending;
	logic                        beat_active;
	logic                        take_tick;
	logic [sns_pkg::TICK_W-1:0]  next_tick;
	sns_pkg::sns_state_t         state;
	logic [sns_pkg::NOTE_AW:0]   idx;

	// Scan datapath.
	logic [sns_pkg::REC_W-1:0]   scan_rec;
	logic                        scan_more;
	logic                        scan_hit;
	logic [sns_pkg::INST_W-1:0]  scan_inst;
	logic [sns_pkg::INST_W-1:0]  decr_inst;
	logic [sns_pkg::DUR_W-1:0]   decr_val;
	logic                        decr_live;
	logic                        decr_last;

	assign beat_pulse = beat_level ^ beat_prev;
	assign buf_full   = note_count[sns_pkg::NOTE_AW];
	assign fill_en    = fetch_busy && !buf_full;
	assign take_tick  = (state == sns_pkg::SNS_IDLE) && tick_pending && beat_active && !beat_pulse;
	assign next_tick  = tick_count + 1'b1;

	assign scan_rec   = note_buf[idx[sns_pkg::NOTE_AW-1:0]];
	assign scan_more  = idx < note_count;
	assign scan_hit   = scan_more && (rec_start(scan_rec) == tick_count);
	assign scan_inst  = rec_inst(scan_rec);
	assign decr_inst  = idx[sns_pkg::INST_W-1:0];
	assign decr_val   = dur_mem[decr_inst];
	assign decr_live  = decr_val != sns_pkg::DUR_RESET;
	assign decr_last  = decr_inst == sns_pkg::INST_W'(sns_pkg::INST_N - 1);

	sns_tick_gen #(
		.TICK_NUM   (TICK_NUM)
	) u_tick_gen (
		.clk        (clk),
		.resetn     (resetn),
		.tempo      (tempo),
		.restart    (beat_pulse),
		.tick_pulse (tick_pulse)
	);

	// Edge detector for the beat level.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			beat_prev <= 1'b0;
		else
			beat_prev <= beat_level;
	end

	// Beat counter, which is also the beat requested from the fetch unit.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			beat_number <= sns_pkg::BEAT_RESET;
		else if (beat_pulse)
			beat_number <= beat_number + 1'b1;
	end

	// Buffer fill pointer and count restart at each beat.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_ptr     <= '0;
			note_count <= '0;
		end
		else if (beat_pulse)
		begin
			wr_ptr     <= '0;
			note_count <= '0;
		end
		else if (fill_en)
		begin
			wr_ptr     <= wr_ptr + 1'b1;
			note_count <= note_count + 1'b1;
		end
	end

	// The buffer has no reset; only entries below the count are ever scanned.
	always_ff @(posedge clk)
	begin
		if (fill_en && !beat_pulse)
			note_buf[wr_ptr] <= fetch_record;
	end

	// Pending tick; a new tick wins over the take that clears it.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			tick_pending <= 1'b0;
		else if (beat_pulse)
			tick_pending <= 1'b0;
		else if (tick_pulse)
			tick_pending <= 1'b1;
		else if (take_tick)
			tick_pending <= 1'b0;
	end

	// The tick counter starts one below zero so the first tick of a beat is zero.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			tick_count  <= sns_pkg::TICK_INIT;
			beat_active <= 1'b0;
		end
		else if (beat_pulse)
		begin
			tick_count  <= sns_pkg::TICK_INIT;
			beat_active <= 1'b1;
		end
		else if (take_tick)
		begin
			tick_count  <= next_tick;
			beat_active <= next_tick != sns_pkg::TICK_LAST;
		end
	end

	// Scan the buffer first, then sweep every instrument for decrement.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state <= sns_pkg::SNS_IDLE;
			idx   <= '0;
		end
		else
		begin
			case (state)
				sns_pkg::SNS_IDLE:
				begin
					idx <= '0;
					if (take_tick)
						state <= sns_pkg::SNS_SCAN;
				end
				sns_pkg::SNS_SCAN:
				begin
					if (scan_more)
						idx <= idx + 1'b1;
					else
					begin
						idx   <= '0;
						state <= sns_pkg::SNS_DECR;
					end
				end
				sns_pkg::SNS_DECR:
				begin
					idx <= idx + 1'b1;
					if (decr_last)
						state <= sns_pkg::SNS_IDLE;
				end
				default:
				begin
					state <= sns_pkg::SNS_IDLE;
				end
			endcase
		end
	end

	// Duration counters; a note started in this tick is also counted down once.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < sns_pkg::INST_N; i++)
				dur_mem[i] <= sns_pkg::DUR_RESET;
		end
		else if (state == sns_pkg::SNS_SCAN && scan_hit)
			dur_mem[scan_inst] <= rec_dur(scan_rec);
		else if (state == sns_pkg::SNS_DECR && decr_live)
			dur_mem[decr_inst] <= decr_val - 1'b1;
	end

	// Instrument enables.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			inst_enable <= '0;
		else if (state == sns_pkg::SNS_SCAN && scan_hit)
			inst_enable[scan_inst] <= 1'b1;
		else if (state == sns_pkg::SNS_DECR && decr_val == sns_pkg::DUR_ONE)
			inst_enable[decr_inst] <= 1'b0;
	end

	// Pitch registers hold their last value after the enable drops.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			inst_pitch <= '0;
		else if (state == sns_pkg::SNS_SCAN && scan_hit)
			inst_pitch[scan_inst*PITCH_W +: PITCH_W] <= rec_pitch(scan_rec);
	end

endmodule // sns_scheduler

// ===== tb/sns_scheduler_assertions.sv
// Purpose: Port checks for the score note scheduler.
// Assumes: One clock; all windows count cycles since the last tick change.
// Notes:   Window bounds allow a full 256-record scan plus the 128-step sweep.
module sns_scheduler_assertions #(
	parameter int unsigned                PITCH_W  = sns_pkg::PITCH_W,
	parameter logic [sns_pkg::NUM_W-1:0]  TICK_NUM = sns_pkg::TICK_NUM
) (
	input  wire logic                                clk,
	input  wire logic                                resetn,
	input  wire logic                                beat_level,
	input  wire logic [sns_pkg::BEAT_W-1:0]          beat_number,
	input  wire logic [sns_pkg::TICK_W-1:0]          tick_count,
	input  wire logic [sns_pkg::INST_N-1:0]          inst_enable,
	input  wire logic [sns_pkg::INST_N*PITCH_W-1:0]  inst_pitch
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic       prev_beat;
	logic       prev_flip;
	logic [6:0] prev_tick;
	logic [9:0] since;
	wire        flip = beat_level != prev_beat;
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			prev_beat <= 1'b0;
			prev_flip <= 1'b0;
			prev_tick <= 7'h7f;
			since <= 10'h000;
		end
		else
		begin
			prev_beat <= beat_level;
			prev_flip <= flip;
			prev_tick <= tick_count;
			since <= (tick_count != prev_tick) ? 10'h000 : since + {9'h000, since != 10'h3ff};
		end
	a_beat_step: assert property (flip |=> beat_number == $past(beat_number) + 12'h001)
		else $error("beat number did not step");
	a_beat_hold: assert property (!flip |=> $stable(beat_number))
		else $error("beat number moved without a beat edge");
	a_tick_restart: assert property (flip |=> tick_count == 7'h7f)
		else $error("tick counter not restarted");
	a_tick_step: assert property (tick_count != prev_tick && !prev_flip |-> tick_count == prev_tick + 7'h01)
		else $error("tick counter skipped");
	a_enable_rise: assert property (|(inst_enable & ~$past(inst_enable)) |-> since <= 10'd264)
		else $error("enable set outside a scan");
	a_enable_fall: assert property (|(~inst_enable & $past(inst_enable)) |-> since <= 10'd400)
		else $error("enable cleared outside a sweep");
	a_pitch_load: assert property (inst_pitch != $past(inst_pitch) |-> since <= 10'd264)
		else $error("pitch changed outside a scan");
	a_reset_values: assert property ($rose(resetn) |-> beat_number == 12'h000 && tick_count == 7'h7f && inst_enable == '0 && inst_pitch == '0)
		else $error("outputs not cleared by reset");
endmodule // sns_scheduler_assertions

bind sns_scheduler sns_scheduler_assertions #(.PITCH_W(PITCH_W), .TICK_NUM(TICK_NUM))
	i_sns_scheduler_assertions (.clk, .resetn, .beat_level, .beat_number, .tick_count,
	.inst_enable, .inst_pitch);

// ===== tb/sns_fetch_model.sv
// Purpose: Note fetch unit model streaming stored records by beat.
// Assumes: Records are loaded in beat order before the first request.
// Notes:   Outside a burst the record lines hold a fixed zeros-over-ones pattern, since noise stays at zero.
module sns_fetch_model (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [11:0]  req_beat,
	input  wire logic         slow,
	output logic              busy,
	output logic [45:0]       record
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [45:0] mem[256];
	int          fill = 0;
	int          addr;
	logic        gap;
	logic [22:0] noise;
	assign busy = addr < fill && mem[addr][45:34] <= req_beat && !(slow && gap);
	assign record = busy ? mem[addr] : {noise, ~noise};
	always_ff @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			addr <= 0;
			gap <= 1'b0;
			noise <= 23'h000000;
		end
		else
		begin
			gap <= ~gap;
			noise <= ~noise + 23'h000001;
			if (busy)
				addr <= addr + 1;
		end
endmodule // sns_fetch_model

// ===== tb/tb.sv
// Purpose: Self-checking bench for the score note scheduler.
// Assumes: A reduced divider numerator gives a 200-cycle tick at tempo 10.
// Notes:   Results are compared late in each tick, once scan and sweep are over.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic         clk;
	logic         resetn;
	logic         beat_level;
	logic         fetch_busy;
	logic         slow;
	logic [9:0]   tempo;
	logic [45:0]  fetch_record;
	logic [45:0]  r;
	logic [11:0]  beat_number;
	logic [6:0]   tick_count;
	logic [127:0] inst_enable;
	logic [127:0] ee;
	logic [895:0] inst_pitch;
	logic [895:0] ep;
	int           miscompares = 0;
	int           num_checks = 0;
	int           dur[128];
	int           w;
	int           n;
	int           cnt;
	bit   [31:0]  rs = 64362;
	logic [45:0]  recs[3][$];
	sns_scheduler #(.TICK_NUM(36'd256000)) i_sns_scheduler (.clk, .resetn, .beat_level,
		.tempo, .fetch_busy, .fetch_record, .beat_number, .tick_count, .inst_enable, .inst_pitch);
	sns_fetch_model i_sns_fetch_model (.clk, .resetn, .req_beat(beat_number), .slow,
		.busy(fetch_busy), .record(fetch_record));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic bit [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic cmp(input logic [895:0] g, input logic [895:0] e);
		num_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic tally_and_finish();
		if (miscompares == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Later records win on a shared instrument; the sweep runs after all starts.
	task automatic step(input int b, input int t);
		for (int k = 0; k < recs[b].size(); k++)
			if (recs[b][k][33:27] == 7'(t))
			begin
				ee[recs[b][k][13:7]] = 1'b1;
				ep[recs[b][k][13:7]*7 +: 7] = recs[b][k][6:0];
				dur[recs[b][k][13:7]] = int'(recs[b][k][26:14]);
			end
		for (int i = 0; i < 128; i++)
			if (dur[i] > 0)
			begin
				dur[i]--;
				if (dur[i] == 0)
					ee[i] = 1'b0;
			end
	endtask
	initial
	begin
		#300000;
		miscompares++;
		tally_and_finish();
	end
	initial
	begin
		beat_level = 1'b0;
		tempo = 10'd10;
		slow = 1'b0;
		resetn = 1'b0;
		ee = '0;
		ep = '0;
		n = 0;
		for (int b = 0; b < 3; b++)
		begin
			cnt = 4 + int'(rnd() % 13);
			for (int k = 0; k < cnt; k++)
			begin
				r = {12'(b + 1), 7'(rnd() % 16), 13'(1 + rnd() % 40), 7'(rnd() % 8), 7'(rnd())};
				recs[b].push_back(r);
				i_sns_fetch_model.mem[n] = r;
				n++;
			end
		end
		i_sns_fetch_model.fill = n;
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		repeat (3) @(negedge clk);
		for (int b = 0; b < 3; b++)
		begin
			slow = b == 1;
			beat_level = ~beat_level;
			repeat (2) @(negedge clk);
			cmp(896'(beat_number), 896'(b + 1));
			cmp(896'(tick_count), 896'(7'h7f));
			for (int t = 0; t <= 20; t++)
			begin
				w = 0;
				while (tick_count !== 7'(t) && w < 400)
				begin
					@(negedge clk);
					w++;
				end
				cmp(896'(tick_count), 896'(t));
				repeat (190) @(negedge clk);
				step(b, t);
				cmp(896'(inst_enable), 896'(ee));
				cmp(inst_pitch, ep);
			end
		end
		resetn = 1'b0;
		@(negedge clk);
		cmp(896'({beat_number, inst_enable}), 896'(0));
		tally_and_finish();
	end
endmodule // tb
